// ==== parallel_host_strobe_and_data_ready_bench.sv ====
`timescale 1ns/1ps
module parallel_host_strobe_and_data_ready_bench import phsdr_pkg::*;;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic cs_n, cs, rd_n, wr_n, sel, oe_n, smp_v = 1'b0, smp_rdy, cclk = 1'b0, rdy_sig, took;
    logic [CW_W-1:0] bd_in, bd_out, cw0, cw1;
    logic [SMP_W-1:0] smp_d = '0;
    logic [1:0] chans = 2'h0;
    logic [CNT_W-1:0] cnt;
    int fail_count = 0;
    int total_checks = 0;
    int cycles = 0;
    // ****************
    // clock, parts, watchdog
    // ****************
    always #4 mclk = ~mclk;
    phsdr_top dut_u (.mclk_i(mclk), .rst_i(rst), .select_low_active_n_i(cs_n),
        .select_high_active_i(cs), .read_n_i(rd_n), .write_n_i(wr_n), .reg_sel_i(sel),
        .bus_data_i(bd_in), .bus_data_o(bd_out), .bus_data_oe_n_o(oe_n), .smp_data_i(smp_d),
        .smp_valid_i(smp_v), .smp_ready_o(smp_rdy), .conversion_clock_i(cclk),
        .chans_m1_i(chans), .fifo_ready_signal_o(rdy_sig), .fifo_count_o(cnt),
        .control_word_zero_o(cw0), .control_word_one_o(cw1));
    phsdr_host_model host_u (.mclk_i(mclk), .cs_n_o(cs_n), .cs_o(cs), .rd_n_o(rd_n),
        .wr_n_o(wr_n), .sel_o(sel), .d_o(bd_in), .q_i(bd_out), .oe_n_i(oe_n));
    // a hang must still end with a verdict
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            results();
        end
    end
    // ****************
    // shared tasks
    // ****************
    task automatic check(input logic [CW_W-1:0] seen, input logic [CW_W-1:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic results();
        if (fail_count == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : results
    task automatic push(input logic [SMP_W-1:0] v);
        int n;
        n = 0;
        @(negedge mclk);
        smp_d = v;
        smp_v = 1'b1;
        while (smp_rdy !== 1'b1 && n < 4) begin
            @(negedge mclk);
            n++;
        end
        took = smp_rdy === 1'b1;
        @(negedge mclk);
        smp_v = 1'b0;
        smp_d = ~v;
    endtask : push
    // read with the given hold, expect one word and an enabled driver
    task automatic rd(input logic [CW_W-1:0] exp, input int hold);
        host_u.acc(2'd0, 1'b0, '0, hold);
        check(host_u.q_last, exp);
        check(16'(host_u.oe_seen), 16'h0);
    endtask : rd
    task automatic wr(input logic s, input logic [CW_W-1:0] d);
        host_u.acc(2'd1, s, d, 1);
        @(negedge mclk);
    endtask : wr
    task automatic cc(input logic lv, input logic exp);
        cclk = lv;
        repeat (4) @(negedge mclk);
        check(16'(rdy_sig), 16'(exp));
    endtask : cc
    // ****************
    // scenarios
    // ****************
    task automatic t_reset_write();
        check(cw0, 16'h0000);
        check(cw1, 16'h0030);
        check({11'h0, cnt}, 16'h0);
        check(16'({oe_n, rdy_sig, smp_rdy}), 16'h5);
        wr(REG_SEL_CW0, 16'ha5c3);
        check(cw0, 16'ha5c3);
        host_u.acc(2'd2, REG_SEL_CW0, 16'h5a5a, 2);
        @(negedge mclk);
        check(cw0, 16'ha5c3);
        check(16'(host_u.oe_seen), 16'h1);
    endtask : t_reset_write
    task automatic t_level();
        chans = 2'h1;
        wr(REG_SEL_CW1, 16'h0020);
        for (int i = 1; i <= 3; i++) push(12'(i * 12'h101));
        repeat (4) @(negedge mclk);
        check(16'(rdy_sig), 16'h1);
        rd(16'h0101, 2);
        check(16'(rdy_sig), 16'h0);
        rd(16'h0202, 6);
        check({11'h0, cnt}, 16'h1);
        check(16'(rdy_sig), 16'h0);
        push(12'h404);
        repeat (4) @(negedge mclk);
        check(16'(rdy_sig), 16'h1);
        rd(16'h0303, 2);
        rd(16'h0404, 2);
        rd(16'h0000, 2);
    endtask : t_level
    task automatic t_fill();
        chans = 2'h0;
        wr(REG_SEL_CW1, 16'h000c);
        check(16'(rdy_sig), 16'h1);
        for (int i = 0; i < FIFO_DEPTH + BUF_DEPTH; i++) begin
            push(12'(i + 12'h10));
            check(16'(took), 16'h1);
        end
        push(12'hfff);
        check(16'(took), 16'h0);
        check({11'h0, cnt}, 16'(FIFO_DEPTH));
        check(16'(rdy_sig), 16'h0);
        for (int i = 0; i < FIFO_DEPTH + BUF_DEPTH; i++) begin
            rd(16'(i + 16'h10), 2);
            if (i == 0) check(16'(rdy_sig), 16'h1);
        end
    endtask : t_fill
    task automatic t_dir();
        wr(REG_SEL_CW1, 16'h0060);
        host_u.rw_mode = 1'b1;
        check(16'(cw1[CW1_RW_BIT]), 16'h1);
        wr(REG_SEL_CW0, 16'h1234);
        check(cw0, 16'h1234);
        push(12'h0aa);
        repeat (4) @(negedge mclk);
        rd(16'h00aa, 3);
        wr(REG_SEL_CW1, 16'h0030);
        host_u.rw_mode = 1'b0;
    endtask : t_dir
    task automatic t_pulse();
        push(12'h0bb);
        cc(1'b0, 1'b0);
        cc(1'b1, 1'b1);
        cc(1'b0, 1'b0);
        push(12'h0cc);
        cc(1'b1, 1'b0);
        cc(1'b0, 1'b0);
        rd(16'h00bb, 2);
        cc(1'b1, 1'b1);
        cc(1'b0, 1'b0);
    endtask : t_pulse
    // main sequence
    initial begin
        repeat (2) @(negedge mclk);
        rst = 1'b0;
        t_reset_write();
        t_level();
        t_fill();
        t_dir();
        t_pulse();
        results();
    end
endmodule : parallel_host_strobe_and_data_ready_bench

// ==== phsdr_host_model.sv ====
`timescale 1ns/1ps
module phsdr_host_model import phsdr_pkg::*; (
    // clock
    input wire logic mclk_i,
    // strobes and data out
    output logic cs_n_o,
    output logic cs_o,
    output logic rd_n_o,
    output logic wr_n_o,
    output logic sel_o,
    output logic [phsdr_pkg::CW_W-1:0] d_o,
    // read side
    input wire logic [phsdr_pkg::CW_W-1:0] q_i,
    input wire logic oe_n_i
);
    logic rw_mode = 1'b0;
    logic [CW_W-1:0] q_last;
    logic oe_seen;
    // idle bus at time zero
    initial begin
        cs_n_o = 1'b1;
        cs_o = 1'b0;
        rd_n_o = 1'b1;
        wr_n_o = 1'b1;
        sel_o = 1'b0;
        d_o = '0;
    end
    // kind 0 read, 1 write, 2 read and write together
    task automatic acc(input logic [1:0] kind, input logic sel, input logic [CW_W-1:0] d,
                       input int hold);
        @(negedge mclk_i);
        sel_o = sel;
        d_o = d;
        // direction first, selects last, so the select starts the strobe
        rd_n_o = rw_mode || kind == 2'd1;
        wr_n_o = kind == 2'd0;
        @(negedge mclk_i);
        cs_n_o = 1'b0;
        cs_o = 1'b1;
        repeat (hold) @(negedge mclk_i);
        q_last = q_i;
        oe_seen = oe_n_i;
        // low select drops first and alone ends the strobe
        cs_n_o = 1'b1;
        @(negedge mclk_i);
        cs_o = 1'b0;
        rd_n_o = 1'b1;
        wr_n_o = 1'b1;
        d_o = ~d;
        sel_o = ~sel;
    endtask : acc
endmodule : phsdr_host_model

// ==== phsdr_pkg.sv ====
package phsdr_pkg;

    // ********************************************
    // widths and depths
    // ********************************************
    localparam int CW_W = 16;
    localparam int SMP_W = 12;
    localparam int FIFO_DEPTH = 16;
    localparam int CNT_W = 5;
    localparam int BUF_DEPTH = 2;

    // ********************************************
    // control word fields
    // ********************************************
    localparam int CW1_TRIG_LO_BIT = 2;
    localparam int CW1_TRIG_HI_BIT = 3;
    localparam int CW1_PULSE_BIT = 4;
    localparam int CW1_POL_BIT = 5;
    localparam int CW1_RW_BIT = 6;
    localparam logic [CW_W-1:0] CW0_RST = 16'h0000;
    localparam logic [CW_W-1:0] CW1_RST = 16'h0030;
    localparam logic REG_SEL_CW0 = 1'b0;
    localparam logic REG_SEL_CW1 = 1'b1;

    // ********************************************
    // data-ready sequencer states
    // ********************************************
    typedef enum logic [2:0] {
        ST_ARMED = 3'b001,
        ST_SIGNAL = 3'b010,
        ST_DRAIN = 3'b100
    } phsdr_state_t;

    // fill threshold: rows by selector, columns by active channels
    // reserved combination maps to the full fifo depth
    function automatic logic [CNT_W-1:0] phsdr_threshold(input logic [1:0] chans_m1,
                                                          input logic [1:0] sel);
        logic [CNT_W-1:0] t;
        t = 5'h01;
        case ({sel, chans_m1})
            4'h0: t = 5'h01;
            4'h1: t = 5'h02;
            4'h2: t = 5'h03;
            4'h3: t = 5'h04;
            4'h4: t = 5'h04;
            4'h5: t = 5'h04;
            4'h6: t = 5'h06;
            4'h7: t = 5'h08;
            4'h8: t = 5'h08;
            4'h9: t = 5'h08;
            4'ha: t = 5'h09;
            4'hb: t = 5'h0c;
            4'hc: t = 5'h0e;
            4'hd: t = 5'h0c;
            4'he: t = 5'h0c;
            default: t = 5'h10;
        endcase
        return t;
    endfunction : phsdr_threshold

endpackage : phsdr_pkg

// ==== phsdr_props.sv ====
`timescale 1ns/1ps
module phsdr_props import phsdr_pkg::*; #(
    parameter int SMP_W = 12,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // host pins
    input wire logic select_low_active_n_i,
    input wire logic select_high_active_i,
    input wire logic read_n_i,
    input wire logic write_n_i,
    input wire logic reg_sel_i,
    input wire logic [phsdr_pkg::CW_W-1:0] bus_data_i,
    input wire logic [phsdr_pkg::CW_W-1:0] bus_data_o,
    input wire logic bus_data_oe_n_o,
    // converter and status
    input wire logic conversion_clock_i,
    input wire logic fifo_ready_signal_o,
    input wire logic [phsdr_pkg::CNT_W-1:0] fifo_count_o,
    input wire logic [phsdr_pkg::CW_W-1:0] control_word_zero_o,
    input wire logic [phsdr_pkg::CW_W-1:0] control_word_one_o
);
    // ****************
    // strobes decoded from the pins
    // ****************
    logic sel_on;
    logic rd_on;
    logic wr_on;
    logic lvl;
    logic hi;
    // read pin is ignored in direction mode, so it must drop out here too
    assign sel_on = !select_low_active_n_i && select_high_active_i;
    assign rd_on = sel_on && (control_word_one_o[CW1_RW_BIT] ? write_n_i : !read_n_i && write_n_i);
    assign wr_on = sel_on && !write_n_i && (control_word_one_o[CW1_RW_BIT] || read_n_i);
    assign lvl = !control_word_one_o[CW1_PULSE_BIT];
    assign hi = control_word_one_o[CW1_POL_BIT];
    default clocking @(posedge mclk_i);
    endclocking
    default disable iff (rst_i);
    // ****************
    // properties
    // ****************
    property p_oe_on;
        rd_on |=> !bus_data_oe_n_o;
    endproperty
    a_oe_on: assert property (p_oe_on) else $error("driver enable missing");
    property p_oe_off;
        !rd_on |=> bus_data_oe_n_o;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("driver enable stuck");
    property p_one_pop;
        rd_on && $past(rd_on) |=> $stable(bus_data_o);
    endproperty
    a_one_pop: assert property (p_one_pop) else $error("second pop in one strobe");
    property p_wr0;
        wr_on && reg_sel_i == REG_SEL_CW0 ##1 !wr_on |=> control_word_zero_o == $past(bus_data_i, 2);
    endproperty
    a_wr0: assert property (p_wr0) else $error("word zero not loaded");
    property p_wr1;
        wr_on && reg_sel_i == REG_SEL_CW1 ##1 !wr_on
            |=> control_word_one_o[CW_W-1:2] == $past(bus_data_i[CW_W-1:2], 2);
    endproperty
    a_wr1: assert property (p_wr1) else $error("word one not loaded");
    property p_cw0_hold;
        !$past(wr_on, 2) |-> $stable(control_word_zero_o);
    endproperty
    a_cw0_hold: assert property (p_cw0_hold) else $error("word zero changed alone");
    property p_lvl_clr;
        lvl && fifo_ready_signal_o == hi && $rose(rd_on) && !wr_on |=> fifo_ready_signal_o == !hi;
    endproperty
    a_lvl_clr: assert property (p_lvl_clr) else $error("level not cleared by read");
    property p_pulse_end;
        (!lvl && !conversion_clock_i && !wr_on) [*3] |=> fifo_ready_signal_o == !hi;
    endproperty
    a_pulse_end: assert property (p_pulse_end) else $error("pulse outlives half period");
    property p_lvl_idle;
        lvl && fifo_count_o == 0 && !wr_on && !$past(wr_on) |=> fifo_ready_signal_o == !hi;
    endproperty
    a_lvl_idle: assert property (p_lvl_idle) else $error("ready while empty");
    property p_empty_rd;
        $rose(rd_on) && fifo_count_o == 0 |=> bus_data_o == '0;
    endproperty
    a_empty_rd: assert property (p_empty_rd) else $error("empty read not zero");
    // main scenarios
    c_full: cover property (fifo_count_o == DEPTH);
    c_pulse: cover property (!lvl && fifo_ready_signal_o == hi);
    c_dir_rd: cover property (control_word_one_o[CW1_RW_BIT] && rd_on);
endmodule : phsdr_props
bind phsdr_top phsdr_props #(.SMP_W(SMP_W), .DEPTH(DEPTH)) props_u (.mclk_i, .rst_i,
    .select_low_active_n_i, .select_high_active_i, .read_n_i, .write_n_i, .reg_sel_i,
    .bus_data_i, .bus_data_o, .bus_data_oe_n_o, .conversion_clock_i, .fifo_ready_signal_o,
    .fifo_count_o, .control_word_zero_o, .control_word_one_o);

// ==== phsdr_skid_buf.sv ====
`timescale 1ns/1ps
module phsdr_skid_buf #(
    parameter int W = phsdr_pkg::SMP_W,
    parameter int DEPTH = phsdr_pkg::BUF_DEPTH
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // filling side
    input wire logic [W-1:0] in_data_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    // draining side
    output logic [W-1:0] out_data_o,
    output logic out_valid_o,
    input wire logic out_ready_i
);
    import phsdr_pkg::*;

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [PW-1:0] wp;
        logic [PW-1:0] rp;
        logic [PW:0] cnt;
    } phsdr_buf_t;

    phsdr_buf_t s_ff;
    phsdr_buf_t nxt_s;
    logic push;
    logic pop;

    // ********************************************
    // flags straight from the occupancy count
    // ********************************************
    assign in_ready_o = (s_ff.cnt != (PW+1)'(DEPTH));
    assign out_valid_o = (s_ff.cnt != '0);
    assign out_data_o = s_ff.mem[s_ff.rp];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    // pointer wrap handles non power of two depths
    always_comb begin
        nxt_s = s_ff;
        if (push) begin
            nxt_s.mem[s_ff.wp] = in_data_i;
            nxt_s.wp = (s_ff.wp == PW'(DEPTH-1)) ? '0 : PW'(s_ff.wp + 1'b1);
        end
        if (pop) begin
            nxt_s.rp = (s_ff.rp == PW'(DEPTH-1)) ? '0 : PW'(s_ff.rp + 1'b1);
        end
        if (push && !pop) begin
            nxt_s.cnt = (PW+1)'(s_ff.cnt + 1'b1);
        end else if (pop && !push) begin
            nxt_s.cnt = (PW+1)'(s_ff.cnt - 1'b1);
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

endmodule : phsdr_skid_buf

// ==== phsdr_top.sv ====
`timescale 1ns/1ps
// Contract
// - read strobe needs both selects, read active, write inactive
// - each read strobe pops one fifo word and drives the data bus; a read of an empty fifo pops nothing and drives zero
// - write strobe needs both selects, write active, read inactive
// - write strobe loads control word zero or control word one
// - strobe ends when the first contributing input goes inactive
// - write input can act as combined read/write direction input
// - bit 4 picks level or pulse, bit 5 picks polarity
// - ready signal goes active once the fill threshold is met
// - level mode: inactive at start of first threshold read
// - after threshold reads the trigger condition is checked again
// - pulse lasts one half conversion clock period
// - no further pulse before threshold words are read out
// - bit 6 set: write pin is direction, read pin ignored
// - threshold from two-bit field and channel count, one reserved
module phsdr_top #(
    parameter int SMP_W = phsdr_pkg::SMP_W,
    parameter int DEPTH = phsdr_pkg::FIFO_DEPTH
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // host bus
    input wire logic select_low_active_n_i,
    input wire logic select_high_active_i,
    input wire logic read_n_i,
    input wire logic write_n_i,
    input wire logic reg_sel_i,
    input wire logic [phsdr_pkg::CW_W-1:0] bus_data_i,
    output logic [phsdr_pkg::CW_W-1:0] bus_data_o,
    output logic bus_data_oe_n_o,
    // conversion word stream
    input wire logic [SMP_W-1:0] smp_data_i,
    input wire logic smp_valid_i,
    output logic smp_ready_o,
    // converter timing and setup
    input wire logic conversion_clock_i,
    input wire logic [1:0] chans_m1_i,
    // status
    output logic fifo_ready_signal_o,
    output logic [phsdr_pkg::CNT_W-1:0] fifo_count_o,
    output logic [phsdr_pkg::CW_W-1:0] control_word_zero_o,
    output logic [phsdr_pkg::CW_W-1:0] control_word_one_o
);
    import phsdr_pkg::*;

    localparam int PW = $clog2(DEPTH);
    // pointers wrap by overflow, so DEPTH must stay a power of two

    // ********************************************
    // state
    // ********************************************
    typedef struct packed {
        // fifo storage and occupancy
        logic [DEPTH-1:0][SMP_W-1:0] mem;
        logic [PW-1:0] wp;
        logic [PW-1:0] rp;
        logic [CNT_W-1:0] cnt;
        // strobe history for edge detection
        logic rd_act;
        logic wr_act;
        // captured write, committed when the strobe ends
        logic [CW_W-1:0] wr_hold;
        logic wr_sel;
        // control words
        logic [CW_W-1:0] cw0;
        logic [CW_W-1:0] cw1;
        // read port
        logic [CW_W-1:0] dout;
        logic oe_n;
        // conversion clock history and ready sequencer
        logic cclk_q;
        phsdr_state_t st;
        logic [CNT_W-1:0] left;
        logic rdy_out;
    } phsdr_core_t;

    phsdr_core_t s_ff;
    phsdr_core_t nxt_s;

    // buffer to fifo
    logic [SMP_W-1:0] buf_data;
    logic buf_valid;
    logic fifo_take;
    // strobe decode
    logic selected;
    logic combined;
    logic rd_cond;
    logic wr_cond;
    logic rd_go;
    logic wr_end;
    // fifo moves and ready terms
    logic pop;
    logic push;
    logic cclk_rise;
    logic cclk_fall;
    logic pulse_mode;
    logic trig_met;
    logic [CNT_W-1:0] thresh;
    logic active;

    // ********************************************
    // helpers
    // ********************************************
    // fifo pointer step; wraps for free at a power-of-two depth
    function automatic logic [PW-1:0] ptr_next(input logic [PW-1:0] p);
        return PW'(p + 1'b1);
    endfunction : ptr_next

    // one-step change of a count; shared by occupancy and drain counter
    function automatic logic [CNT_W-1:0] cnt_step(input logic [CNT_W-1:0] c, input logic up);
        return up ? CNT_W'(c + 1'b1) : CNT_W'(c - 1'b1);
    endfunction : cnt_step

    // pin level for an activity flag under the programmed polarity
    function automatic logic pin_level(input logic act, input logic pol);
        return pol ? act : !act;
    endfunction : pin_level

    // ********************************************
    // input skid buffer
    // ********************************************
    // two entries so a full fifo stalls the source without losing a word
    // the buffer's ready goes straight back to the source
    phsdr_skid_buf #(
        .W(SMP_W),
        .DEPTH(BUF_DEPTH)
    ) u_buf (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .in_data_i(smp_data_i),
        .in_valid_i(smp_valid_i),
        .in_ready_o(smp_ready_o),
        .out_data_o(buf_data),
        .out_valid_o(buf_valid),
        .out_ready_i(fifo_take)
    );

    // ********************************************
    // strobe decode
    // ********************************************
    // pins are taken as synchronous; the host must give one mclk of setup
    // combined mode: write pin high means read, read pin is ignored
    assign combined = s_ff.cw1[CW1_RW_BIT];
    assign selected = !select_low_active_n_i && select_high_active_i;
    // any input leaving its active level drops the strobe at once
    assign rd_cond = combined ? (selected && write_n_i)
                              : (selected && !read_n_i && write_n_i);
    assign wr_cond = combined ? (selected && !write_n_i)
                              : (selected && !write_n_i && read_n_i);
    // reads act on the rising edge, writes on the falling edge, so a long strobe counts once
    assign rd_go = rd_cond && !s_ff.rd_act;
    assign wr_end = s_ff.wr_act && !wr_cond;

    // ********************************************
    // fifo handshake
    // ********************************************
    // the buffer may refill a full fifo in the cycle a read frees a slot
    assign fifo_take = (s_ff.cnt != CNT_W'(DEPTH)) || rd_go;
    assign push = buf_valid && fifo_take;
    // an empty read pops nothing and returns zero
    assign pop = rd_go && (s_ff.cnt != '0);

    // ********************************************
    // conversion clock edges and trigger terms
    // ********************************************
    // conversion clock is sampled; its edges must be slower than mclk_i
    // the pulse spans sampled rise to sampled fall, half a conversion period
    assign cclk_rise = conversion_clock_i && !s_ff.cclk_q;
    assign cclk_fall = !conversion_clock_i && s_ff.cclk_q;
    assign pulse_mode = s_ff.cw1[CW1_PULSE_BIT];
    assign thresh = phsdr_threshold(chans_m1_i,
                                    s_ff.cw1[CW1_TRIG_HI_BIT:CW1_TRIG_LO_BIT]);
    assign trig_met = (s_ff.cnt >= thresh);

    // ********************************************
    // next-state logic
    // ********************************************
    always_comb begin
        nxt_s = s_ff;
        active = 1'b0;
        // strobe and clock history follow the pins every cycle
        nxt_s.rd_act = rd_cond;
        nxt_s.wr_act = wr_cond;
        nxt_s.cclk_q = conversion_clock_i;

        // fifo storage: push and pop may share a cycle
        if (push) begin
            nxt_s.mem[s_ff.wp] = buf_data;
            nxt_s.wp = ptr_next(s_ff.wp);
        end
        if (pop) begin
            nxt_s.rp = ptr_next(s_ff.rp);
        end
        if (push && !pop) begin
            nxt_s.cnt = cnt_step(s_ff.cnt, 1'b1);
        end else if (pop && !push) begin
            nxt_s.cnt = cnt_step(s_ff.cnt, 1'b0);
        end

        // read data is latched at strobe start; empty fifo reads zero
        if (rd_go) begin
            nxt_s.dout = (s_ff.cnt != '0) ? CW_W'(s_ff.mem[s_ff.rp]) : '0;
        end
        nxt_s.oe_n = !rd_cond;

        // data is held until the strobe ends, matching the setup window
        if (wr_cond) begin
            nxt_s.wr_hold = bus_data_i;
            nxt_s.wr_sel = reg_sel_i;
        end
        // the committed word shows one cycle after the strobe drops
        if (wr_end) begin
            if (s_ff.wr_sel == REG_SEL_CW1) begin
                nxt_s.cw1 = s_ff.wr_hold;
            end else begin
                nxt_s.cw0 = s_ff.wr_hold;
            end
        end

        // ready sequencer
        // armed: waiting for the fill threshold
        // signal: output active; level mode leaves on the first read
        // drain: output idle until the threshold count of words is read
        case (s_ff.st)
            ST_ARMED: begin
                // pulse mode also waits for a conversion clock rise
                if (trig_met && (!pulse_mode || cclk_rise)) begin
                    nxt_s.st = ST_SIGNAL;
                    nxt_s.left = thresh;
                end
            end
            ST_SIGNAL: begin
                if (pop) begin
                    nxt_s.left = cnt_step(s_ff.left, 1'b0);
                end
                if (!pulse_mode && rd_go) begin
                    nxt_s.st = (s_ff.left == 5'h01) ? ST_ARMED : ST_DRAIN;
                end else if (pulse_mode && cclk_fall) begin
                    nxt_s.st = ST_DRAIN;
                end
            end
            ST_DRAIN: begin
                if (pop) begin
                    nxt_s.left = cnt_step(s_ff.left, 1'b0);
                end
                if (s_ff.left == '0 || (pop && s_ff.left == 5'h01)) begin
                    nxt_s.st = ST_ARMED;
                end
            end
            default: begin
                nxt_s.st = ST_ARMED;
            end
        endcase

        // pulse ending after all threshold reads goes straight back to armed
        if (s_ff.st == ST_SIGNAL && nxt_s.st == ST_DRAIN && nxt_s.left == '0) begin
            nxt_s.st = ST_ARMED;
        end

        // polarity applied at the flop so the pin never glitches
        active = (nxt_s.st == ST_SIGNAL);
        nxt_s.rdy_out = pin_level(active, s_ff.cw1[CW1_POL_BIT]);

        // any write to control word one restarts the sequencer
        // the new polarity applies at once so the pin shows idle
        if (wr_end && s_ff.wr_sel == REG_SEL_CW1) begin
            nxt_s.st = ST_ARMED;
            nxt_s.rdy_out = pin_level(1'b0, s_ff.wr_hold[CW1_POL_BIT]);
        end
    end

    // ********************************************
    // state register
    // ********************************************
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            // all zero except the programmed reset words, the armed state and idle pins
            s_ff <= '0;
            s_ff.cw0 <= CW0_RST;
            s_ff.cw1 <= CW1_RST;
            s_ff.oe_n <= 1'b1;
            s_ff.st <= ST_ARMED;
            s_ff.rdy_out <= !CW1_RST[CW1_POL_BIT];
        end else begin
            s_ff <= nxt_s;
        end
    end

    // ********************************************
    // outputs, all from flops
    // ********************************************
    // registered outputs keep the pins free of decode glitches
    assign bus_data_o = s_ff.dout;
    assign bus_data_oe_n_o = s_ff.oe_n;
    assign fifo_ready_signal_o = s_ff.rdy_out;
    assign fifo_count_o = s_ff.cnt;
    assign control_word_zero_o = s_ff.cw0;
    assign control_word_one_o = s_ff.cw1;

endmodule : phsdr_top
